// [bus_init_assertions.sv]
// Purpose: bank port checks
// Assumes: one-cycle strobes
// Notes: bound below
`default_nettype none
module bus_init_assertions(input wire logic ref_clk,rst,io_rd,io_wr,
  input wire logic [15:0] io_addr,input wire logic [1:0] printer_base_sel,
  input wire logic io_claim,ext_cycle,ext_data_buffer_out_en,bank_locked,
  input wire logic bank_unlocked,printer_port_hit);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire bnk=io_addr[9:1]==9'h1EA&&!bank_locked;
  wire ur=io_rd&&io_addr[9:0]==10'h3D5;
  a_hit_claim: assert property((io_rd|io_wr)&&bnk|=>io_claim)
    else $error("no claim");
  a_lock_fwd: assert property($past(bank_locked)|->!io_claim)
    else $error("claimed");
  a_unlock_src: assert property($rose(bank_unlocked)|->$past(ur))
    else $error("bad unlock");
  a_early_lock: assert property($rose(bank_locked)|->bank_unlocked)
    else $error("early lock");
  a_lock_held: assert property(bank_locked|=>bank_locked)
    else $error("lock lost");
  a_buf_off: assert property(io_claim|->!ext_data_buffer_out_en)
    else $error("buffer on");
  a_even_hid: assert property(io_rd&&!io_addr[0]&&bnk|=>!ext_cycle)
    else $error("even read shown");
  a_sel_held: assert property(bank_locked|=>$stable(printer_base_sel))
    else $error("sel moved");
  a_prn_buf_off: assert property(printer_port_hit|->!ext_data_buffer_out_en)
    else $error("buffer on for printer");
  c_unl: cover property($rose(bank_unlocked));
  c_lck: cover property($rose(bank_locked));
  c_fwd: cover property(ext_data_buffer_out_en&&bank_locked);
endmodule
bind bus_init_index_registers bus_init_assertions chk(.*);
`default_nettype wire

// [bus_init_defines.vh]
// Purpose: constants for the bus-initialization index bank
// Assumes: 16-bit I/O address from the core, byte data
// Notes: index values are bank register indices
`ifndef BUS_INIT_DEFINES_VH
`define BUS_INIT_DEFINES_VH
`define IO_DECODE_MASK 10'h3FF
`define PTR_PORT_ADDR 10'h3D4
`define DATA_PORT_ADDR 10'h3D5
`define IDX_UNLOCK 8'h12
`define IDX_LOCK 8'h19
`define IDX_PRN_SEL 8'h20
`define PRN_SEL_RESET 2'h1
`define PRN_SEL_LSB 0
`define PRN_SEL_MSB 1
`define PRN_OFF 2'h0
`define PRN_3BX 2'h1
`define PRN_37X 2'h2
`define PRN_27X 2'h3
`define PRN_BASE_3BX 10'h3BC
`define PRN_BASE_37X 10'h378
`define PRN_BASE_27X 10'h278
`define PRN_SPAN_MASK 10'h3F8
`define PRN_BASE_NONE 10'h000
`define IDX_RESET 8'h00
`define RESERVED_READ 8'h00
`endif

// [bus_init_index_registers.v]
// Purpose: indexed bus-initialization bank behind ports 3D4h/3D5h
// Assumes: I/O strobes are one-cycle pulses from on-chip logic
// Notes: internal decode ignores address bits above bit 9
`include "bus_init_defines.vh"
`default_nettype none
module bus_init_index_registers (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // processor I/O cycle
  input wire [15:0] io_addr,
  input wire [7:0] io_wdata,
  input wire io_rd,
  input wire io_wr,
  // answer to the core
  output reg [7:0] io_rdata,
  output reg io_claim,
  // external bus side
  output reg ext_cycle,
  output reg [15:0] ext_addr,
  output reg [7:0] ext_data,
  output reg ext_data_oe,
  output reg ext_rd,
  output reg ext_wr,
  output reg ext_data_buffer_out_en,
  // configuration state and printer window hit
  output reg [1:0] printer_base_sel,
  output reg bank_unlocked,
  output reg bank_locked,
  output reg printer_port_hit
);

  // bank state and its next values
  reg [7:0] index_q;
  reg [7:0] index_d;
  reg [1:0] prn_sel_q;
  reg [1:0] prn_sel_d;
  reg unlock_q;
  reg unlock_d;
  reg lock_q;
  reg lock_d;

  // address decode
  wire [9:0] a10;
  wire hit_ptr;
  wire hit_data;
  wire bank_active;
  wire io_any;
  reg [9:0] prn_base;
  wire prn_hit;
  wire internal_acc;
  wire internal_any;
  wire even_rd_hidden;

  // bank strobes qualified by decode
  wire ptr_wr;
  wire data_rd;
  wire data_wr;
  wire unlock_rd;
  wire lock_wr;
  wire sel_wr;

  // mirror every 400h
  // upper bits ignored, so 7D5h also hits the data port;
  // a peripheral placed above 3FFh can collide with this bank
  assign a10 = io_addr[9:0] & `IO_DECODE_MASK;
  assign hit_ptr = (a10 == `PTR_PORT_ADDR);
  assign hit_data = (a10 == `DATA_PORT_ADDR);
  assign io_any = io_rd | io_wr;

  assign bank_active = !lock_q;
  assign internal_acc = bank_active && (hit_ptr || hit_data);

  // pointer write-only, data both ways
  // a read of the pointer port is claimed but changes nothing
  assign ptr_wr = bank_active && io_wr && hit_ptr;
  assign data_rd = bank_active && io_rd && hit_data;
  assign data_wr = bank_active && io_wr && hit_data;

  assign unlock_rd = data_rd && (index_q == `IDX_UNLOCK);

  // lock write, data value not checked
  // reserved bits are the caller's duty, so any value locks
  assign lock_wr = data_wr && unlock_q && (index_q == `IDX_LOCK);

  assign sel_wr = data_wr && unlock_q && (index_q == `IDX_PRN_SEL);

  always @* begin
    case (prn_sel_q)
      `PRN_3BX: prn_base = `PRN_BASE_3BX;
      `PRN_37X: prn_base = `PRN_BASE_37X;
      `PRN_27X: prn_base = `PRN_BASE_27X;
      default: prn_base = `PRN_BASE_NONE;
    endcase
  end

  // both sides masked, so 3BCh sits in its eight-byte window
  assign prn_hit = (prn_sel_q != `PRN_OFF) &&
                   ((a10 & `PRN_SPAN_MASK) ==
                    (prn_base & `PRN_SPAN_MASK));

  // printer window counts as internal too
  assign internal_any = internal_acc || prn_hit;

  // even internal reads stay off the outside lines
  assign even_rd_hidden = internal_any && io_rd && !io_addr[0];

  // pointer follows the last pointer write
  always @* begin
    index_d = index_q;
    if (ptr_wr)
      index_d = io_wdata;
  end

  always @* begin
    unlock_d = unlock_q;
    if (unlock_rd)
      unlock_d = 1'b1;
  end

  // lock sticky; bank ignored after it
  always @* begin
    lock_d = lock_q;
    if (lock_wr)
      lock_d = 1'b1;
  end

  always @* begin
    prn_sel_d = prn_sel_q;
    if (sel_wr)
      prn_sel_d = io_wdata[`PRN_SEL_MSB:`PRN_SEL_LSB];
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      index_q <= `IDX_RESET;
      prn_sel_q <= `PRN_SEL_RESET;
      unlock_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      index_q <= index_d;
      prn_sel_q <= prn_sel_d;
      unlock_q <= unlock_d;
      lock_q <= lock_d;
    end
  end

  // answer to the core, one cycle after the strobe
  always @(posedge ref_clk) begin
    if (rst) begin
      io_rdata <= `RESERVED_READ;
      io_claim <= 1'b0;
    end else begin
      // registers are write-only; reads return zero
      io_rdata <= `RESERVED_READ;
      io_claim <= io_any && internal_acc;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      ext_cycle <= 1'b0;
      ext_addr <= 16'h0000;
      ext_data <= 8'h00;
      ext_data_oe <= 1'b0;
      ext_rd <= 1'b0;
      ext_wr <= 1'b0;
    end else begin
      ext_cycle <= io_any && !even_rd_hidden;
      ext_addr <= io_addr;
      ext_data <= io_wdata;
      ext_data_oe <= io_wr;
      ext_rd <= io_rd && !even_rd_hidden;
      ext_wr <= io_wr;
    end
  end

  // after lock the ports count as external
  always @(posedge ref_clk) begin
    if (rst)
      ext_data_buffer_out_en <= 1'b0;
    else
      ext_data_buffer_out_en <= io_any && !internal_any;
  end

  // levels load the next values, so they show one cycle
  // after the strobe, in step with the pulses
  always @(posedge ref_clk) begin
    if (rst) begin
      printer_base_sel <= `PRN_SEL_RESET;
      bank_unlocked <= 1'b0;
      bank_locked <= 1'b0;
    end else begin
      printer_base_sel <= prn_sel_d;
      bank_unlocked <= unlock_d;
      bank_locked <= lock_d;
    end
  end

  always @(posedge ref_clk) begin
    if (rst)
      printer_port_hit <= 1'b0;
    else
      printer_port_hit <= io_any && prn_hit;
  end

endmodule
`default_nettype wire

// [bus_init_index_registers_tb.sv]
// Purpose: row bench for index bank
// Assumes: core model drives cycles
// Notes: reset repeated after the rows
`default_nettype none
module bus_init_index_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk=0,rst=1;
  wire [15:0] io_addr,ext_addr;
  wire [7:0] io_wdata,io_rdata,ext_data;
  wire [1:0] printer_base_sel;
  wire io_rd,io_wr,io_claim,ext_cycle,ext_data_oe,ext_rd,ext_wr;
  wire ext_data_buffer_out_en,bank_unlocked,bank_locked,printer_port_hit;
  int miscompares=0,check_count=0;
  // addr, data, write, {claim,shown,buffer,sel}
  // select before lock, lock data 20h
  logic [25:0] rows[12]='{{12'h3D4,8'h12,1'h1,5'h19},
    {12'h3D5,8'h03,1'h1,5'h19},{12'h7D5,8'h00,1'h0,5'h19},
    {12'h3D4,8'h00,1'h0,5'h11},{12'h3D4,8'h20,1'h1,5'h19},
    {12'h3D5,8'h00,1'h1,5'h18},{12'h3D5,8'h03,1'h1,5'h1B},
    {12'hBD5,8'h02,1'h1,5'h1A},{12'h3D4,8'h19,1'h1,5'h1A},
    {12'h3D5,8'h20,1'h1,5'h1A},{12'h3D5,8'h01,1'h1,5'h0E},
    {12'h378,8'h00,1'h0,5'h02}};
  io_core_model cpu(.*);
  bus_init_index_registers DUT(.*);
  initial forever #2.5 ref_clk=~ref_clk;
  task chk(input logic [7:0] g,e);
    check_count++;
    if (g!==e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h",$time,g,e);
    end
  endtask
  task final_report;
    $display("checks=%0d miscompares=%0d",check_count,miscompares);
    if (miscompares==0&&check_count>0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #2000;
    miscompares++;
    final_report;
  end
  initial begin
    repeat(20) @(negedge ref_clk);
    rst=0;
    foreach(rows[i]) begin
      cpu.acc({4'h0,rows[i][25:14]},rows[i][13:6],rows[i][5]);
      chk({3'h0,io_claim,ext_cycle,ext_data_buffer_out_en,printer_base_sel},
        {3'h0,rows[i][4:0]});
      chk({ext_rd,ext_wr,ext_data_oe,printer_port_hit,4'h0},
        {!rows[i][5]&&rows[i][3],rows[i][5],rows[i][5],
        rows[i][25:14]==12'h378,4'h0});
      chk(ext_addr[7:0],rows[i][21:14]);
      chk(ext_data,rows[i][13:6]);
      chk(io_rdata,8'h00);
    end
    chk({6'h0,bank_unlocked,bank_locked},8'h03);
    rst=1;
    @(negedge ref_clk) rst=0;
    chk({4'h0,bank_unlocked,bank_locked,printer_base_sel},
      8'h01);
    cpu.acc(16'h03BD,8'h00,1'b0);
    chk({5'h0,printer_port_hit,ext_cycle,ext_data_buffer_out_en},
      8'h06);
    cpu.acc(16'h03D4,8'h20,1'b1);
    cpu.acc(16'h03D5,8'h03,1'b1);
    chk({4'h0,bank_unlocked,bank_locked,printer_base_sel},
      8'h01);
    cpu.acc(16'h03D4,8'h12,1'b1);
    cpu.acc(16'h03D5,8'h00,1'b0);
    cpu.acc(16'h03D4,8'h20,1'b1);
    cpu.acc(16'h03D5,8'h03,1'b1);
    chk({4'h0,bank_unlocked,bank_locked,printer_base_sel},
      8'h0B);
    final_report;
  end
endmodule
`default_nettype wire

// [io_core_model.sv]
// Purpose: core issuing I/O cycles
// Assumes: strobes set at falling edge
// Notes: one strobe per access
`default_nettype none
module io_core_model(input wire logic ref_clk,output logic [15:0] io_addr,
  output logic [7:0] io_wdata,output logic io_rd,io_wr);
  timeunit 1ns;
  timeprecision 1ps;
  initial {io_addr,io_wdata,io_rd,io_wr}='0;
  task acc(input logic [15:0] a,input logic [7:0] d,input logic w);
    @(negedge ref_clk) {io_addr,io_wdata,io_wr,io_rd}={a,d,w,!w};
    @(negedge ref_clk) {io_rd,io_wr}='0;
  endtask
endmodule
`default_nettype wire
